// ==== src/uart_dual.sv ====
// two serial channels with irda, lin and rs485 modes behind an axi4-lite slave
`timescale 1ns/1ps
module uart_channel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register access
  input wire logic wr_stb,
  input wire logic [3:0] wr_off,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic rd_stb,
  input wire logic [3:0] rd_off,
  output logic [31:0] rd_data,
  // serial pins
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  output logic tx_pin,
  output logic rts_n_pin,
  output logic wake
);
  import uart_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (val & m);
  endfunction

  function automatic logic par_of(input logic [8:0] d, input logic [3:0] nbits);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < nbits)
        p = p ^ d[i];
    return p;
  endfunction

  logic [31:0] line_ctrl;
  logic [31:0] fifo_ctrl;
  logic [15:0] baud_div;
  logic [31:0] tmo_reg;
  logic [6:0] stat;
  logic [15:0] baud_cnt;
  logic tick;
  logic [2:0] rx_sync;
  logic [2:0] cts_sync;
  logic rx_f;
  logic cts_f;
  logic cts_prev;
  logic [4:0] irda_hold;
  logic [8:0] tx_head;
  logic [8:0] rx_head;
  logic [4:0] tx_cnt;
  logic [4:0] rx_cnt;
  tx_state_e tx_state;
  logic [11:0] tx_ticks;
  logic [3:0] tx_bits;
  logic [8:0] tx_shift;
  logic tx_par;
  logic tx_bit;
  rx_state_e rx_state;
  logic [3:0] rx_ticks;
  logic [3:0] rx_bits;
  logic [8:0] rx_shift;
  logic rx_allz;
  logic rx_prev;
  logic rx_push;
  logic [8:0] rx_word;
  logic ev_par;
  logic ev_frm;
  logic ev_brk;
  logic [7:0] tmo_cnt;
  logic [3:0] tmo_sub;
  logic brk_clear;

  // decode of register strobes and configuration fields
  wire wr_line = wr_stb && wr_off == OFF_LINE;
  wire wr_fifo = wr_stb && wr_off == OFF_FIFO;
  wire wr_char = wr_stb && wr_off == OFF_DATA && wr_strb[0];
  wire wr_stat = wr_stb && wr_off == OFF_STAT && wr_strb[0];
  wire rx_pop = rd_stb && rd_off == OFF_DATA;
  wire [1:0] mode = line_ctrl[LINE_MODE_LSB +: 2];
  wire irda = mode == MODE_IRDA;
  wire lin = mode == MODE_LIN;
  wire rs485 = mode == MODE_RS485;
  wire nine = rs485 && line_ctrl[LINE_NINE_BIT];
  wire [3:0] nbits = nine ? 4'h9 : {2'h0, line_ctrl[LINE_WLEN_LSB +: 2]} + 4'h5;
  wire par_en = line_ctrl[LINE_PAR_EN];
  wire par_even = line_ctrl[LINE_PAR_EVEN];
  wire par_stick = line_ctrl[LINE_PAR_STICK];
  wire [1:0] stop_sel = line_ctrl[LINE_STOP_LSB +: 2];
  wire [5:0] stop_ticks = (stop_sel == 2'h0) ? STOP_1 : (stop_sel == 2'h1) ? STOP_15 : STOP_2;
  wire [7:0] tmo_val = tmo_reg[TMO_CNT_LSB +: 8];
  wire [7:0] gap_bits = tmo_reg[GAP_LSB +: 8];
  wire [7:0] brk_bits = tmo_reg[BRK_LEN_LSB +: 8];
  wire [4:0] rx_trig_lvl = {1'b0, fifo_ctrl[FCR_RX_TRIG_LSB +: 4]} + 5'h01;
  wire [4:0] rts_lvl = {1'b0, fifo_ctrl[FCR_RTS_TRIG_LSB +: 4]} + 5'h01;
  wire rx_clr = wr_fifo && wr_strb[1] && wr_data[FCR_RX_CLR];
  wire tx_clr = wr_fifo && wr_strb[1] && wr_data[FCR_TX_CLR];
  // divisor is only sixteen bits; the upper merged half is dropped on purpose
  wire [31:0] baud_wr = merge({16'h0000, baud_div}, wr_data, wr_strb);

  // registers; a hardware clear of the break request loses to a software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_ctrl <= LINE_RST;
      fifo_ctrl <= FIFO_RST;
      baud_div <= BAUD_RST;
      tmo_reg <= TMO_RST;
    end
    else
    begin
      if (brk_clear)
        line_ctrl[LINE_BRK_REQ] <= 1'b0;
      if (wr_line)
        line_ctrl <= merge(line_ctrl, wr_data, wr_strb) & LINE_MASK;
      if (wr_fifo)
        fifo_ctrl <= merge(fifo_ctrl, wr_data, wr_strb) & FIFO_MASK;
      if (wr_stb && wr_off == OFF_BAUD)
        baud_div <= baud_wr[15:0];
      if (wr_stb && wr_off == OFF_TMO)
        tmo_reg <= merge(tmo_reg, wr_data, wr_strb) & TMO_MASK;
    end
  end

  // sixteen-times oversample tick from this channel's own divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn || baud_cnt >= baud_div)
      baud_cnt <= '0;
    else
      baud_cnt <= baud_cnt + 16'h0001;
    tick <= aresetn && baud_cnt >= baud_div;
  end

  // pin synchronisers; a level is taken once the second and third stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sync <= 3'h7;
      cts_sync <= 3'h7;
      rx_f <= 1'b1;
      cts_f <= 1'b1;
      cts_prev <= 1'b1;
    end
    else
    begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      cts_sync <= {cts_sync[1:0], cts_n_pin};
      if (rx_sync[2] == rx_sync[1])
        rx_f <= rx_sync[2];
      if (cts_sync[2] == cts_sync[1])
        cts_f <= cts_sync[2];
      cts_prev <= cts_f;
    end
  end

  // irda receive: a short high pulse marks a zero bit, stretched over one bit time
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !irda)
      irda_hold <= '0;
    else if (rx_f)
      irda_hold <= IRDA_HOLD;
    else if (tick && irda_hold != 5'h00)
      irda_hold <= irda_hold - 5'h01;
  end
  wire rx_line = irda ? (irda_hold == 5'h00) : rx_f;

  // queues
  wire tx_full = tx_cnt == FIFO_FULL;
  wire rx_full = rx_cnt == FIFO_FULL;
  wire brk_start = tx_state == TX_IDLE && line_ctrl[LINE_BRK_REQ];
  wire brk_len_ok = lin && brk_bits != 8'h00;
  wire cts_ok = !line_ctrl[LINE_AUTO_FLOW] || rs485 || !cts_f;
  wire tx_go = tx_state == TX_IDLE && !brk_start && tx_cnt != 5'h00 && cts_ok;

  uart_fifo u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(tx_clr),
    .push(wr_char),
    .wdata(wr_data[8:0]),
    .pop(tx_go),
    .head(tx_head),
    .count(tx_cnt)
  );

  uart_fifo u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rx_clr),
    .push(rx_push),
    .wdata(rx_word),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_cnt)
  );

  // transmitter element timing
  wire [11:0] tx_len = (tx_state == TX_STOP) ? {6'h00, stop_ticks} :
                       (tx_state == TX_GAP) ? {gap_bits, 4'h0} :
                       (tx_state == TX_BRK) ? {brk_bits, 4'h0} : BIT_TICKS;
  wire tx_elem_end = tick && tx_ticks == tx_len - 12'h001;
  assign brk_clear = (brk_start && !brk_len_ok) || (tx_state == TX_BRK && tx_elem_end);
  wire tx_par_bit = par_stick ? ~par_even : (par_even ? tx_par : ~tx_par);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= TX_IDLE;
      tx_ticks <= '0;
      tx_bits <= '0;
      tx_shift <= '0;
      tx_par <= 1'b0;
      tx_bit <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_ticks <= tx_elem_end ? 12'h000 : tx_ticks + 12'h001;
      case (tx_state)
        TX_IDLE:
        begin
          tx_ticks <= '0;
          tx_bit <= 1'b1;
          if (brk_start && brk_len_ok)
          begin
            tx_state <= TX_BRK;
            tx_bit <= 1'b0;
          end
          else if (tx_go)
          begin
            tx_state <= TX_START;
            tx_shift <= tx_head;
            tx_par <= par_of(tx_head, nbits);
            tx_bit <= 1'b0;
          end
        end
        TX_BRK:
          if (tx_elem_end)
          begin
            tx_state <= TX_STOP;
            tx_bit <= 1'b1;
          end
        TX_START:
          if (tx_elem_end)
          begin
            tx_state <= TX_DATA;
            tx_bits <= '0;
            tx_bit <= tx_shift[0];
          end
        TX_DATA:
          if (tx_elem_end)
          begin
            tx_shift <= tx_shift >> 1;
            tx_bits <= tx_bits + 4'h1;
            tx_bit <= tx_shift[1];
            if (tx_bits == nbits - 4'h1)
            begin
              tx_state <= par_en ? TX_PAR : TX_STOP;
              tx_bit <= par_en ? tx_par_bit : 1'b1;
            end
          end
        TX_PAR:
          if (tx_elem_end)
          begin
            tx_state <= TX_STOP;
            tx_bit <= 1'b1;
          end
        TX_STOP:
          if (tx_elem_end)
            tx_state <= (gap_bits != 8'h00) ? TX_GAP : TX_IDLE;
        TX_GAP:
          if (tx_elem_end)
            tx_state <= TX_IDLE;
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver; samples land mid-bit after the start bit is confirmed at its centre
  wire rx_samp = tick && rx_ticks == ((rx_state == RX_START) ? RX_MID : RX_LAST);
  wire [8:0] rx_char = rx_shift >> (4'h9 - nbits);
  wire rx_par_exp = par_stick ? ~par_even :
                    (par_even ? par_of(rx_char, nbits) : ~par_of(rx_char, nbits));
  wire rx_is_brk = rx_allz && !rx_line;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state <= RX_IDLE;
      rx_ticks <= '0;
      rx_bits <= '0;
      rx_shift <= '0;
      rx_allz <= 1'b0;
      rx_prev <= 1'b1;
      rx_push <= 1'b0;
      rx_word <= '0;
      ev_par <= 1'b0;
      ev_frm <= 1'b0;
      ev_brk <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      ev_par <= 1'b0;
      ev_frm <= 1'b0;
      ev_brk <= 1'b0;
      if (tick)
      begin
        rx_prev <= rx_line;
        rx_ticks <= rx_samp ? 4'h0 : rx_ticks + 4'h1;
      end
      case (rx_state)
        RX_IDLE:
        begin
          rx_ticks <= '0;
          if (tick && rx_prev && !rx_line)
            rx_state <= RX_START;
        end
        RX_START:
          if (rx_samp)
          begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_bits <= '0;
            rx_allz <= 1'b1;
          end
        RX_DATA:
          if (rx_samp)
          begin
            rx_shift <= {rx_line, rx_shift[8:1]};
            rx_allz <= rx_allz & ~rx_line;
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == nbits - 4'h1)
              rx_state <= par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_samp)
          begin
            ev_par <= rx_line != rx_par_exp;
            rx_allz <= rx_allz & ~rx_line;
            rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_samp)
          begin
            ev_brk <= rx_is_brk;
            ev_frm <= !rx_line && !rx_is_brk;
            rx_push <= !rx_is_brk;
            rx_word <= rx_char;
            rx_state <= RX_IDLE;
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // receive timeout counts whole bit times while unread data sits idle
  wire tmo_hold = rx_push || rx_pop || rx_cnt == 5'h00 || rx_state != RX_IDLE || tmo_val == 8'h00;
  wire ev_tmo = !tmo_hold && tick && tmo_sub == 4'hf && tmo_cnt == tmo_val - 8'h01;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tmo_hold)
    begin
      tmo_cnt <= '0;
      tmo_sub <= '0;
    end
    else if (tick)
    begin
      tmo_sub <= tmo_sub + 4'h1;
      if (tmo_sub == 4'hf && tmo_cnt != tmo_val)
        tmo_cnt <= tmo_cnt + 8'h01;
    end
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  wire ev_cts = cts_prev != cts_f;
  wire [6:0] ev_set = {ev_cts, ev_tmo, ev_brk, ev_frm, ev_par, wr_char && tx_full,
                       rx_push && rx_full};
  wire [6:0] ev_clr = wr_stat ? wr_data[6:0] : 7'h00;
  wire rx_trig = rx_cnt >= rx_trig_lvl;
  wire tx_empty = tx_cnt == 5'h00;
  wire tx_busy = tx_state != TX_IDLE;
  wire [6:0] src = {stat[1] | stat[0], stat[6], stat[5], stat[4], stat[3] | stat[2],
                    tx_empty, rx_trig};
  wire rts_flow = line_ctrl[LINE_AUTO_FLOW] ? (rx_cnt < rts_lvl) : line_ctrl[LINE_RTS_SW];
  wire rts_dir = line_ctrl[LINE_AUTO_DIR] ? (tx_busy || !tx_empty) : line_ctrl[LINE_RTS_SW];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat <= '0;
      tx_pin <= 1'b1;
      rts_n_pin <= 1'b1;
      wake <= 1'b0;
    end
    else
    begin
      stat <= (stat & ~ev_clr) | ev_set;
      tx_pin <= irda ? (!tx_bit && tx_ticks < IRDA_PULSE) : tx_bit;
      rts_n_pin <= rs485 ? ~rts_dir : ~rts_flow;
      wake <= line_ctrl[LINE_WAKE_EN] && stat[6];
    end
  end

  wire [31:0] stat_word = {3'h0, rx_cnt, 1'b0, src, 2'h0, tx_busy, cts_f, tx_full,
                           rx_cnt == 5'h00, tx_empty, rx_trig, 1'b0, stat};
  assign rd_data = (rd_off == OFF_DATA) ? {23'h000000, rx_head} :
                   (rd_off == OFF_LINE) ? line_ctrl :
                   (rd_off == OFF_FIFO) ? fifo_ctrl :
                   (rd_off == OFF_BAUD) ? {16'h0000, baud_div} :
                   (rd_off == OFF_TMO) ? tmo_reg :
                   (rd_off == OFF_STAT) ? stat_word : 32'h0000_0000;
endmodule // uart_channel

module uart_dual (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [uart_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [uart_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // channel 0 pins
  input wire logic rx0,
  input wire logic cts0_n,
  output logic tx0,
  output logic rts0_n,
  output logic wake0,
  // channel 1 pins
  input wire logic rx1,
  input wire logic cts1_n,
  output logic tx1,
  output logic rts1_n,
  output logic wake1
);
  import uart_pkg::*;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return !a[UNMAP_BIT] && a[5:2] <= OFF_STAT && a[1:0] == 2'h0;
  endfunction

  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic [31:0] ch_rd [NUM_CH];
  logic [NUM_CH-1:0] rx_in;
  logic [NUM_CH-1:0] cts_in;
  logic [NUM_CH-1:0] tx_out;
  logic [NUM_CH-1:0] rts_out;
  logic [NUM_CH-1:0] wake_out;

  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire ar_take = arvalid && arready;
  wire do_wr = aw_held && w_held && !bvalid;
  wire next_aw_held = !do_wr && (aw_held || aw_take);
  wire next_w_held = !do_wr && (w_held || w_take);
  wire next_bvalid = bvalid ? !bready : do_wr;
  wire next_rvalid = rvalid ? !rready : ar_take;
  wire wr_ok = addr_ok(aw_addr);
  wire rd_ok = addr_ok(araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
      bvalid <= next_bvalid;
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (aw_take)
        aw_addr <= awaddr;
      if (w_take)
      begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_wr)
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (ar_take)
      begin
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        rdata <= rd_ok ? ch_rd[araddr[CH_SEL_BIT]] : 32'h0000_0000;
      end
    end
  end

  assign rx_in = {rx1, rx0};
  assign cts_in = {cts1_n, cts0_n};
  assign tx0 = tx_out[0];
  assign tx1 = tx_out[1];
  assign rts0_n = rts_out[0];
  assign rts1_n = rts_out[1];
  assign wake0 = wake_out[0];
  assign wake1 = wake_out[1];

  // two identical, independent channels
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    uart_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_stb(do_wr && wr_ok && aw_addr[CH_SEL_BIT] == 1'(i)),
      .wr_off(aw_addr[5:2]),
      .wr_data(w_data),
      .wr_strb(w_strb),
      .rd_stb(ar_take && rd_ok && araddr[CH_SEL_BIT] == 1'(i)),
      .rd_off(araddr[5:2]),
      .rd_data(ch_rd[i]),
      .rx_pin(rx_in[i]),
      .cts_n_pin(cts_in[i]),
      .tx_pin(tx_out[i]),
      .rts_n_pin(rts_out[i]),
      .wake(wake_out[i])
    );
  end
endmodule // uart_dual

// ==== pkg/uart_pkg.sv ====
// shared constants and state types for the dual serial channel block
package uart_pkg;
  localparam int NUM_CH = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int CHAR_W = 9;
  localparam int ADDR_W = 8;
  localparam logic [FIFO_AW:0] FIFO_FULL = 5'h10;
  // register word offsets inside one channel window
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_LINE = 4'h1;
  localparam logic [3:0] OFF_FIFO = 4'h2;
  localparam logic [3:0] OFF_BAUD = 4'h3;
  localparam logic [3:0] OFF_TMO = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h5;
  localparam int CH_SEL_BIT = 6;
  localparam int UNMAP_BIT = 7;
  // line control fields
  localparam int LINE_WLEN_LSB = 0;
  localparam int LINE_STOP_LSB = 2;
  localparam int LINE_PAR_EN = 4;
  localparam int LINE_PAR_EVEN = 5;
  localparam int LINE_PAR_STICK = 6;
  localparam int LINE_BRK_REQ = 7;
  localparam int LINE_MODE_LSB = 8;
  localparam int LINE_AUTO_FLOW = 10;
  localparam int LINE_AUTO_DIR = 11;
  localparam int LINE_RTS_SW = 12;
  localparam int LINE_NINE_BIT = 13;
  localparam int LINE_WAKE_EN = 14;
  localparam logic [31:0] LINE_MASK = 32'h0000_7fff;
  localparam logic [31:0] LINE_RST = 32'h0000_0003;
  // fifo control fields
  localparam int FCR_RX_TRIG_LSB = 0;
  localparam int FCR_RTS_TRIG_LSB = 4;
  localparam int FCR_RX_CLR = 8;
  localparam int FCR_TX_CLR = 9;
  localparam logic [31:0] FIFO_MASK = 32'h0000_00ff;
  localparam logic [31:0] FIFO_RST = 32'h0000_00e0;
  // timeout and gap fields
  localparam int TMO_CNT_LSB = 0;
  localparam int GAP_LSB = 8;
  localparam int BRK_LEN_LSB = 16;
  localparam logic [31:0] TMO_MASK = 32'h00ff_ffff;
  localparam logic [31:0] TMO_RST = 32'h000d_0000;
  localparam logic [15:0] BAUD_RST = 16'h000a;
  // function modes
  localparam logic [1:0] MODE_UART = 2'h0;
  localparam logic [1:0] MODE_IRDA = 2'h1;
  localparam logic [1:0] MODE_LIN = 2'h2;
  localparam logic [1:0] MODE_RS485 = 2'h3;
  // bit timing in oversample ticks
  localparam logic [3:0] RX_MID = 4'h7;
  localparam logic [3:0] RX_LAST = 4'hf;
  localparam logic [11:0] BIT_TICKS = 12'h010;
  localparam logic [11:0] IRDA_PULSE = 12'h003;
  localparam logic [5:0] STOP_1 = 6'h10;
  localparam logic [5:0] STOP_15 = 6'h18;
  localparam logic [5:0] STOP_2 = 6'h20;
  localparam logic [4:0] IRDA_HOLD = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01, TX_START = 7'h02, TX_DATA = 7'h04, TX_PAR = 7'h08,
    TX_STOP = 7'h10, TX_GAP = 7'h20, TX_BRK = 7'h40
  } tx_state_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_e;
endpackage

// ==== src/uart_fifo.sv ====
// sixteen-entry character queue with registered head output
`timescale 1ns/1ps
module uart_fifo (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic clr,
  input wire logic push,
  input wire logic [uart_pkg::CHAR_W-1:0] wdata,
  input wire logic pop,
  // state
  output logic [uart_pkg::CHAR_W-1:0] head,
  output logic [uart_pkg::FIFO_AW:0] count
);
  import uart_pkg::*;
  logic [CHAR_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr;
  logic [FIFO_AW-1:0] rptr;
  wire full = count == FIFO_FULL;
  wire empty = count == '0;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;
  wire [FIFO_AW-1:0] next_rptr = do_pop ? rptr + 1'b1 : rptr;
  wire [FIFO_AW:0] next_count = (do_push & ~do_pop) ? count + 1'b1 :
                                (do_pop & ~do_push) ? count - 1'b1 : count;
  // bypass keeps the head register in step with the count when a char lands on an empty queue
  wire bypass = do_push && wptr == next_rptr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      head <= '0;
    end
    else
    begin
      if (do_push)
        wptr <= wptr + 1'b1;
      rptr <= next_rptr;
      count <= next_count;
      head <= bypass ? wdata : mem[next_rptr];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (do_push)
      mem[wptr] <= wdata;
  end
endmodule // uart_fifo

// ==== tb/uart_dual_monitor.sv ====
// register port checker for the serial block
`timescale 1ns/1ps
module uart_dual_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // read side
  input wire logic [uart_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  import uart_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar;
    arvalid && arready;
  endsequence
  sequence s_wboth;
    awvalid && awready && wvalid && wready;
  endsequence
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_bdone;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_wans;
    s_wboth |-> ##2 bvalid;
  endproperty
  property p_rans;
    s_ar |=> rvalid ##0 !arready;
  endproperty
  property p_rbusy;
    rvalid |-> !arready;
  endproperty
  property p_wbusy;
    bvalid |-> !awready && !wready;
  endproperty
  // unmapped reads must never leak stale data
  property p_unmap;
    s_ar ##0 araddr[UNMAP_BIT] |=> rresp == RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  a_rhold: assert property (p_rhold) else $error("read response not held");
  a_bdone: assert property (p_bdone) else $error("write response not released");
  a_wans: assert property (p_wans) else $error("write response late");
  a_rans: assert property (p_rans) else $error("read response late");
  a_rbusy: assert property (p_rbusy) else $error("read address taken while busy");
  a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
  a_unmap: assert property (p_unmap) else $error("unmapped read answered wrongly");
endmodule // uart_dual_monitor
bind uart_dual uart_dual_monitor uart_dual_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

// ==== tb/serial_peer.sv ====
// remote serial peer on the channel 0 line, eight data bits, no parity
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 16
) (
  // clock
  input wire logic aclk,
  // line
  input wire logic tx,
  output logic rx
);
  logic [7:0] got;
  int cnt = 0;
  initial rx = 1'b1;
  task automatic send(input logic [7:0] b);
    rx <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      rx <= b[i];
      repeat (BIT) @(posedge aclk);
    end
    rx <= 1'b1;
    repeat (BIT) @(posedge aclk);
  endtask
  // samples mid-bit; stop level is not judged here
  always
  begin
    @(negedge tx);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge aclk);
      got[i] = tx;
    end
    repeat (BIT) @(posedge aclk);
    cnt++;
  end
endmodule // serial_peer

// ==== tb/uart_dual_tb_top.sv ====
// bench for the dual serial block over its register port
`timescale 1ns/1ps
module uart_dual_tb_top;
  import uart_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rx0, tx0;
  logic tx1, rts0_n, rts1_n, wake0, wake1;
  logic cts0_n = 1;
  logic [1:0] bresp, rresp, rs;
  int errors = 0, compares = 0, k;
  always #25 aclk = ~aclk;
  // channel 1 inputs are parked idle; channel 0 carries traffic
  uart_dual uart_dual_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx0(rx0), .cts0_n(cts0_n), .tx0(tx0), .rts0_n(rts0_n), .wake0(wake0), .rx1(1'b1),
    .cts1_n(1'b1), .tx1(tx1), .rts1_n(rts1_n), .wake1(wake1));
  serial_peer serial_peer_inst (.aclk(aclk), .tx(tx0), .rx(rx0));
  task automatic summarize;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, m = '1);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(n, rd & m, e);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("line", 8'h04, 32'h0000_0003);
    rchk("fifo", 8'h08, 32'h0000_00e0);
    rchk("tmo", 8'h10, 32'h000d_0000);
    rchk("stat0", 8'h14, 32'h0, 32'h7f);
    chk("idle", {tx1, rts1_n, rts0_n, wake1, wake0}, 32'h1c);
    cts0_n <= 1'b0;
    repeat (8) @(posedge aclk);
    rchk("ctschg", 8'h14, 32'h40, 32'h40);
    wr(8'h04, 32'h5003);
    @(posedge aclk);
    chk("wake", {rts0_n, wake0}, 32'h1);
    wr(8'h0c, 32'h0);
    rchk("baud1", 8'h4c, 32'h0000_000a);
    rchk("unmap", 8'h80, 32'h0);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    wr(8'h18, 32'h1);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    for (k = 0; k < 18; k++) wr(8'h00, 32'h40 + k);
    rchk("txovf", 8'h14, 32'h2, 32'h2);
    for (k = 0; k < 4000 && serial_peer_inst.cnt < 17; k++) @(posedge aclk);
    chk("txlast", {24'h0, serial_peer_inst.got}, 32'h50);
    chk("txcnt", 32'(serial_peer_inst.cnt), 32'd17);
    for (k = 0; k < 17; k++) serial_peer_inst.send(8'h30 + 8'(k));
    repeat (40) @(posedge aclk);
    rchk("rxovf", 8'h14, 32'h1000_0001, 32'h1f00_0001);
    for (k = 0; k < 16; k++) rchk("rxdata", 8'h00, 32'h30 + k);
    rchk("rxempty", 8'h14, 32'h400, 32'h400);
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize;
  end
endmodule // uart_dual_tb_top
